// File: cwd_config_loader.sv
// Configuration word latch, program-once port and identity registers.
// Assumes the nonvolatile words arrive as pins, asynchronous to mclk.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "cwd_params.svh"

module cwd_config_loader
    import cwd_pkg::*;
#(
    parameter logic [7:0] FAMILY_ID = 8'h5a,   // Arbitrary value.
    parameter logic [7:0] PART_ID = 8'ha5,     // Arbitrary value.
    parameter logic [3:0] REVISION = 4'h3,     // Arbitrary value.
    parameter logic [6:0] LAST_PAGE = 7'h7f
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [23:0] nv_word3,
    input wire logic [23:0] nv_word4,
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic prog_req,
    output logic prog_sel_word4,
    output logic [23:0] prog_data,
    output logic cfg_valid,
    output logic osc_crystal_enable,
    output logic secondary_clock_input_digital,
    output logic battery_brownout_enable,
    output cwd_protect_s protect,
    input wire logic [6:0] write_page,
    output logic write_page_blocked,
    input wire logic deep_sleep_sw_enable,
    input wire logic in_deep_sleep,
    output logic deep_sleep_permit,
    output logic deep_sleep_watchdog_run,
    output logic deep_sleep_watchdog_low_power_rc_oscillator,
    output logic [5:0] deep_sleep_watchdog_div_log2,
    output logic brownout_reset_active
);

    logic [23:0] w3_meta_r;
    logic [23:0] w3_sync_r;
    logic [23:0] w4_meta_r;
    logic [23:0] w4_sync_r;
    cwd_word3_s word3_r;
    cwd_word4_s word4_r;
    cwd_state_e state_r;
    cwd_state_e state_nxt;
    logic [1:0] settle_r;
    logic done3_r;
    logic done4_r;
    logic prog_req_r;
    logic prog_sel_r;
    logic [23:0] prog_data_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // Pins pass two flops; only the second stage feeds the capture.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w3_meta_r <= `CWD_ERASED;
            w3_sync_r <= `CWD_ERASED;
            w4_meta_r <= `CWD_ERASED;
            w4_sync_r <= `CWD_ERASED;
        end
        else
        begin
            w3_meta_r <= nv_word3;
            w3_sync_r <= w3_meta_r;
            w4_meta_r <= nv_word4;
            w4_sync_r <= w4_meta_r;
        end
    end

    // The capture waits for the synchroniser to fill after reset release.
    always_comb
    begin
        case (state_r)
            CWD_SYNC: state_nxt = (settle_r == 2'h2) ? CWD_CAPTURE : CWD_SYNC;
            CWD_CAPTURE: state_nxt = CWD_HOLD;
            CWD_HOLD: state_nxt = CWD_HOLD;
            default: state_nxt = CWD_SYNC;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= CWD_SYNC;
            settle_r <= 2'h0;
        end
        else
        begin
            state_r <= state_nxt;
            settle_r <= (state_r == CWD_SYNC) ? settle_r + 2'h1 : settle_r;
        end
    end

    // Fields are taken once and never change until the next reset.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            word3_r <= `CWD_ERASED;
            word4_r <= `CWD_ERASED;
        end
        else if (state_r == CWD_CAPTURE)
        begin
            word3_r <= w3_sync_r | `CWD_W3_ONES;
            word4_r <= w4_sync_r | `CWD_W4_ONES;
        end
    end

    assign cfg_valid = (state_r == CWD_HOLD);

    // Decoded controls for the consuming blocks.
    assign osc_crystal_enable = word3_r.secondary_osc_select;
    assign secondary_clock_input_digital = ~word3_r.secondary_osc_select;
    assign battery_brownout_enable = word3_r.battery_brownout_enable;

    // The page field is a page number of 256 instruction words.
    // On small parts bit 6 is kept zero by the programmer, so no masking here.
    wire [6:0] bound_page = word3_r.protect_boundary_page;
    wire seg_on = ~word3_r.segment_protect_disable;
    wire end_sel = word3_r.protect_end_select;
    wire cfg_forced = end_sel | (bound_page == LAST_PAGE);
    wire cfg_page_prot = seg_on & (cfg_forced | ~word3_r.config_page_protect_select);

    assign protect.enable = seg_on;
    assign protect.low_page = end_sel ? bound_page : 7'h00;
    assign protect.high_page = end_sel ? LAST_PAGE : bound_page;
    assign protect.config_page = cfg_page_prot;

    wire in_segment = (write_page >= protect.low_page) & (write_page <= protect.high_page);
    wire is_cfg_page = (write_page == LAST_PAGE);
    assign write_page_blocked = is_cfg_page ? cfg_page_prot : (seg_on & in_segment);

    // Deep sleep and its watchdog.
    assign deep_sleep_permit = word4_r.deep_sleep_sw_control & deep_sleep_sw_enable;
    assign deep_sleep_watchdog_run = word4_r.deep_sleep_watchdog_enable;
    assign deep_sleep_watchdog_low_power_rc_oscillator = word4_r.deep_sleep_watchdog_clock_select;
    assign deep_sleep_watchdog_div_log2 =
        {1'b0, word4_r.deep_sleep_watchdog_postscale} + `CWD_PS_BASE;
    // Brown-out reset stays live outside deep sleep whatever the bit says.
    assign brownout_reset_active =
        ~in_deep_sleep | word4_r.deep_sleep_brownout_enable;

    // Program port: each word once per reset, bits may only go from one to zero.
    wire hit_w3 = (reg_addr == `CWD_OFS_WORD3);
    wire hit_w4 = (reg_addr == `CWD_OFS_WORD4);
    wire prog3 = reg_wr & hit_w3 & ~done3_r & cfg_valid;
    wire prog4 = reg_wr & hit_w4 & ~done4_r & cfg_valid;
    wire [23:0] clr3 = word3_r & reg_wdata[23:0] | `CWD_W3_ONES;
    wire [23:0] clr4 = word4_r & reg_wdata[23:0] | `CWD_W4_ONES;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done3_r <= 1'b0;
            done4_r <= 1'b0;
            prog_req_r <= 1'b0;
            prog_sel_r <= 1'b0;
            prog_data_r <= `CWD_ERASED;
        end
        else
        begin
            done3_r <= done3_r | prog3;
            done4_r <= done4_r | prog4;
            prog_req_r <= prog3 | prog4;
            if (prog3 | prog4)
            begin
                prog_sel_r <= prog4;
                prog_data_r <= prog4 ? clr4 : clr3;
            end
        end
    end

    assign prog_req = prog_req_r;
    assign prog_sel_word4 = prog_sel_r;
    assign prog_data = prog_data_r;

    // Read side: data stand only in the cycle after the strobe.
    wire [23:0] ident_word = {`CWD_IDENT_ONES, FAMILY_ID, PART_ID};
    wire [23:0] rev_word = {20'h00000, REVISION};
    wire [23:0] status_word = {21'h000000, done4_r, done3_r, cfg_valid};

    always_comb
    begin
        rdata_nxt = 32'h00000000;
        if (reg_rd)
        begin
            case (reg_addr)
                `CWD_OFS_WORD3: rdata_nxt = {8'h00, word3_r};
                `CWD_OFS_WORD4: rdata_nxt = {8'h00, word4_r};
                `CWD_OFS_IDENT: rdata_nxt = {8'h00, ident_word};
                `CWD_OFS_REV: rdata_nxt = {8'h00, rev_word};
                `CWD_OFS_STATUS: rdata_nxt = {8'h00, status_word};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_r <= 32'h00000000;
        else
            rdata_r <= rdata_nxt;
    end

    assign reg_rdata = rdata_r;

    // Checks.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    property p_hold_const;
        cfg_valid |=> $stable(word3_r) && $stable(word4_r);
    endproperty
    a_hold_const: assert property (p_hold_const)
        else $error("Configuration changed after capture.");

    property p_capture_time;
        $rose(rst_n) |-> ##4 cfg_valid;
    endproperty
    a_capture_time: assert property (p_capture_time)
        else $error("Capture did not finish on time.");

    property p_osc;
        state_r == CWD_CAPTURE |=> osc_crystal_enable == $past(w3_sync_r[`CWD_W3_OSC_SEL])
            && secondary_clock_input_digital != osc_crystal_enable;
    endproperty
    a_osc: assert property (p_osc)
        else $error("Oscillator select not taken from the captured word.");

    property p_low_bound;
        seg_on && end_sel |-> protect.low_page == bound_page && protect.high_page == LAST_PAGE;
    endproperty
    a_low_bound: assert property (p_low_bound)
        else $error("Lower boundary mode wrong.");

    property p_high_bound;
        !end_sel |-> protect.low_page == 7'h00 && protect.high_page == bound_page;
    endproperty
    a_high_bound: assert property (p_high_bound)
        else $error("Upper boundary mode wrong.");

    property p_cfg_forced;
        seg_on && (end_sel || bound_page == LAST_PAGE) |-> protect.config_page;
    endproperty
    a_cfg_forced: assert property (p_cfg_forced)
        else $error("Config page left unprotected.");

    property p_disable;
        word3_r.segment_protect_disable |-> !write_page_blocked;
    endproperty
    a_disable: assert property (p_disable)
        else $error("Write blocked while protection disabled.");

    property p_ds_permit;
        !word4_r.deep_sleep_sw_control |-> !deep_sleep_permit;
    endproperty
    a_ds_permit: assert property (p_ds_permit)
        else $error("Deep sleep permitted while unavailable.");

    property p_bor;
        !in_deep_sleep |-> brownout_reset_active;
    endproperty
    a_bor: assert property (p_bor)
        else $error("Brown-out reset lost outside deep sleep.");

    property p_div;
        deep_sleep_watchdog_div_log2 == {1'b0, word4_r.deep_sleep_watchdog_postscale} + 6'h05;
    endproperty
    a_div: assert property (p_div)
        else $error("Postscaler exponent wrong.");

    property p_prog_once;
        prog_req && !prog_sel_word4 |-> ##1 (!prog_req || prog_sel_word4) [*3];
    endproperty
    a_prog_once: assert property (p_prog_once)
        else $error("Third word programmed twice.");

    property p_prog_clear;
        prog_req |-> prog_data == ((prog_sel_word4 ? word4_r : word3_r) & prog_data);
    endproperty
    a_prog_clear: assert property (p_prog_clear)
        else $error("Program tried to set a bit.");

    property p_rd_ident;
        reg_rd && reg_addr == `CWD_OFS_IDENT |=> reg_rdata == {8'h00, 8'hff, FAMILY_ID, PART_ID};
    endproperty
    a_rd_ident: assert property (p_rd_ident)
        else $error("Identity read wrong.");

    property p_rd_rev;
        reg_rd && reg_addr == `CWD_OFS_REV |=> reg_rdata[31:4] == 28'h0000000;
    endproperty
    a_rd_rev: assert property (p_rd_rev)
        else $error("Revision upper bits not zero.");

    property p_rd_w4;
        reg_rd && reg_addr == `CWD_OFS_WORD4 |=> reg_rdata[23:9] == 15'h7fff;
    endproperty
    a_rd_w4: assert property (p_rd_w4)
        else $error("Fourth word reserved bits not one.");

    c_program3: cover property (prog_req && !prog_sel_word4);
    c_program4: cover property (prog_req && prog_sel_word4);
    c_blocked: cover property (write_page_blocked && protect.config_page);
    c_deep_sleep: cover property (deep_sleep_permit && brownout_reset_active);

endmodule // cwd_config_loader

`default_nettype wire

// File: cwd_config_loader_tb_top.sv
// Self-checking testbench for the configuration word and identity block.
// Assumes cwd_pkg and cwd_params.svh are compiled first; the bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none
`include "cwd_params.svh"

module cwd_config_loader_tb_top
    import cwd_pkg::*;
;
    localparam logic [7:0] FAM = 8'h5a; // Arbitrary value.
    localparam logic [7:0] PART = 8'ha5; // Arbitrary value.
    localparam logic [3:0] REVISION_CODE = 4'h3; // Arbitrary value.
    logic mclk, rst_n, reg_wr, reg_rd, prog_req, prog_sel_word4, cfg_valid;
    logic osc_crystal_enable, secondary_clock_input_digital, battery_brownout_enable;
    logic write_page_blocked, deep_sleep_sw_enable, in_deep_sleep, deep_sleep_permit;
    logic deep_sleep_watchdog_run, deep_sleep_watchdog_low_power_rc_oscillator, brownout_reset_active;
    logic [23:0] nv_word3, nv_word4, prog_data;
    logic [4:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [6:0] write_page;
    logic [5:0] deep_sleep_watchdog_div_log2;
    cwd_protect_s protect;
    int num_errors, n_checks;

    cwd_config_loader #(.FAMILY_ID(FAM), .PART_ID(PART), .REVISION(REVISION_CODE), .LAST_PAGE(7'h7f))
        cwd_config_loader_inst (.mclk(mclk), .rst_n(rst_n), .nv_word3(nv_word3),
        .nv_word4(nv_word4), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_req(prog_req),
        .prog_sel_word4(prog_sel_word4), .prog_data(prog_data), .cfg_valid(cfg_valid),
        .osc_crystal_enable(osc_crystal_enable),
        .secondary_clock_input_digital(secondary_clock_input_digital),
        .battery_brownout_enable(battery_brownout_enable), .protect(protect),
        .write_page(write_page), .write_page_blocked(write_page_blocked),
        .deep_sleep_sw_enable(deep_sleep_sw_enable), .in_deep_sleep(in_deep_sleep),
        .deep_sleep_permit(deep_sleep_permit),
        .deep_sleep_watchdog_run(deep_sleep_watchdog_run),
        .deep_sleep_watchdog_low_power_rc_oscillator(deep_sleep_watchdog_low_power_rc_oscillator),
        .deep_sleep_watchdog_div_log2(deep_sleep_watchdog_div_log2),
        .brownout_reset_active(brownout_reset_active));

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    function automatic logic [23:0] w3f(input logic e, input logic c, input logic d,
                                        input logic o, input logic v, input logic [6:0] p);
        return {8'hff, e, c, d, 4'hf, o, v, p};
    endfunction

    // The words must stay put through the capture window, so they change only in reset.
    task automatic boot(input logic [23:0] w3, input logic [23:0] w4);
        int k;
        @(posedge mclk);
        rst_n <= 1'b0;
        nv_word3 <= w3;
        nv_word4 <= w4;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        k = 0;
        while (cfg_valid !== 1'b1 && k < 20)
        begin
            @(negedge mclk);
            k++;
        end
        chk("cfg_valid", {31'h0, cfg_valid}, 32'h1);
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(negedge mclk);
    endtask

    task automatic page_is(input logic [6:0] pg, input logic exp);
        @(posedge mclk);
        write_page <= pg;
        @(negedge mclk);
        chk("write_page_blocked", {31'h0, write_page_blocked}, {31'h0, exp});
    endtask

    // Every postscaler code, with the fourth word's single-bit fields and the oscillator and battery bits walked through both values.
    task automatic t_fields;
        logic [4:0] c;
        logic [23:0] w4;
        logic [31:0] d;
        for (int n = 0; n < 32; n++)
        begin
            c = n[4:0];
            w4 = {15'h7fff, c[0], c[1], c[2], c[3], c};
            boot(w3f(1'b1, 1'b1, 1'b1, c[0], c[1], 7'h00), w4);
            chk("osc", {31'h0, osc_crystal_enable}, {31'h0, c[0]});
            chk("sclk", {31'h0, secondary_clock_input_digital}, {31'h0, ~c[0]});
            chk("vbat_bor", {31'h0, battery_brownout_enable}, {31'h0, c[1]});
            chk("dswdt_run", {31'h0, deep_sleep_watchdog_run}, {31'h0, c[1]});
            chk("dswdt_low_power_rc_oscillator", {31'h0, deep_sleep_watchdog_low_power_rc_oscillator}, {31'h0, c[3]});
            chk("div_log2", {26'h0, deep_sleep_watchdog_div_log2}, n + 5);
            chk("prot_en", {31'h0, protect.enable}, 32'h0);
            for (int m = 0; m < 4; m++)
            begin
                @(posedge mclk);
                deep_sleep_sw_enable <= m[0];
                in_deep_sleep <= m[1];
                @(negedge mclk);
                chk("ds_permit", {31'h0, deep_sleep_permit}, {31'h0, c[0] & m[0]});
                chk("bor", {31'h0, brownout_reset_active}, {31'h0, ~m[1] | c[2]});
            end
            rd(`CWD_OFS_WORD4, d);
            chk("word4", d, {8'h00, w4 | `CWD_W4_ONES});
        end
    endtask

    task automatic t_protect;
        // The programmer side keeps boundary bit 6 clear in these low-page cases.
        boot(w3f(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 7'h10), `CWD_ERASED);
        chk("protect", {16'h0, protect}, {16'h0, 1'b1, 7'h00, 7'h10, 1'b0});
        page_is(7'h00, 1'b1);
        page_is(7'h10, 1'b1);
        page_is(7'h11, 1'b0);
        page_is(7'h7f, 1'b0);
        boot(w3f(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 7'h10), `CWD_ERASED);
        chk("protect", {16'h0, protect}, {16'h0, 1'b1, 7'h10, 7'h7f, 1'b1});
        page_is(7'h0f, 1'b0);
        page_is(7'h10, 1'b1);
        page_is(7'h7f, 1'b1);
        boot(w3f(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 7'h7f), `CWD_ERASED);
        chk("cfg_page", {31'h0, protect.config_page}, 32'h1);
        page_is(7'h7f, 1'b1);
        boot(w3f(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 7'h10), `CWD_ERASED);
        page_is(7'h10, 1'b0);
        page_is(7'h7f, 1'b0);
    endtask

    task automatic t_regs;
        logic [23:0] w3, w4;
        logic [31:0] d;
        w3 = w3f(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 7'h35);
        w4 = 24'hfffeb7;
        boot(w3, w4);
        rd(`CWD_OFS_IDENT, d);
        chk("ident", d, {8'h00, `CWD_IDENT_ONES, FAM, PART});
        rd(`CWD_OFS_REV, d);
        chk("rev", d, {28'h0, REVISION_CODE});
        rd(5'h14, d);
        chk("unmapped", d, 32'h0);
        wr(`CWD_OFS_IDENT, 32'h0);
        chk("ident_wr_req", {31'h0, prog_req}, 32'h0);
        rd(`CWD_OFS_IDENT, d);
        chk("ident_ro", d, {8'h00, `CWD_IDENT_ONES, FAM, PART});
        wr(`CWD_OFS_WORD3, 32'h00f0c3);
        chk("req3", {31'h0, prog_req}, 32'h1);
        chk("sel3", {31'h0, prog_sel_word4}, 32'h0);
        chk("data3", {8'h0, prog_data}, {8'h0, (w3 & 24'h00f0c3) | `CWD_W3_ONES});
        @(negedge mclk);
        chk("req_pulse", {31'h0, prog_req}, 32'h0);
        wr(`CWD_OFS_WORD3, 32'h0);
        chk("req_again", {31'h0, prog_req}, 32'h0);
        rd(`CWD_OFS_WORD3, d);
        chk("word3", d, {8'h00, w3 | `CWD_W3_ONES});
        wr(`CWD_OFS_WORD4, 32'h000055);
        chk("req4", {31'h0, prog_req}, 32'h1);
        chk("sel4", {31'h0, prog_sel_word4}, 32'h1);
        chk("data4", {8'h0, prog_data}, {8'h0, (w4 & 24'h000055) | `CWD_W4_ONES});
        rd(`CWD_OFS_STATUS, d);
        chk("status", d, 32'h7);
        rd(`CWD_OFS_WORD4, d);
        chk("word4", d, {8'h00, w4 | `CWD_W4_ONES});
    endtask

    // About 1,000 cycles are needed; the limit leaves a wide margin.
    initial
    begin
        #(40 * 6000);
        num_errors++;
        conclude;
    end

    initial
    begin
        rst_n = 1'b0;
        nv_word3 = `CWD_ERASED;
        nv_word4 = `CWD_ERASED;
        reg_addr = 5'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        write_page = 7'h00;
        deep_sleep_sw_enable = 1'b0;
        in_deep_sleep = 1'b0;
        num_errors = 0;
        n_checks = 0;
        t_fields;
        t_protect;
        t_regs;
        conclude;
    end
endmodule // cwd_config_loader_tb_top
`default_nettype wire

// File: cwd_params.svh
// Constants for the configuration word and identity block.
// Included by the design module and the testbench; holds definitions only.
`ifndef CWD_PARAMS_SVH
`define CWD_PARAMS_SVH

// Register byte offsets on the plain register port.
`define CWD_OFS_WORD3 5'h00
`define CWD_OFS_WORD4 5'h04
`define CWD_OFS_IDENT 5'h08
`define CWD_OFS_REV 5'h0c
`define CWD_OFS_STATUS 5'h10

// Field positions in the third configuration word.
`define CWD_W3_END_SEL 15
`define CWD_W3_CFG_SEL 14
`define CWD_W3_DISABLE 13
`define CWD_W3_RSVD 9
`define CWD_W3_OSC_SEL 8
`define CWD_W3_VBAT_BOR 7
`define CWD_W3_PAGE_MSB 6

// Field positions in the fourth configuration word.
`define CWD_W4_DS_CTRL 8
`define CWD_W4_DSWDT_EN 7
`define CWD_W4_DS_BOR 6
`define CWD_W4_DSWDT_CLK 5

// Erased value, forced-one masks and the postscaler offset.
`define CWD_ERASED 24'hffffff
`define CWD_W3_ONES 24'hff0200
`define CWD_W4_ONES 24'hfffe00
`define CWD_IDENT_ONES 8'hff
`define CWD_PS_BASE 6'h05
`define CWD_ZERO24 24'h000000

`endif

// File: cwd_pkg.sv
// Types shared by the configuration word and identity block.
// Holds types only; the numeric constants live in cwd_params.svh.
`default_nettype none

package cwd_pkg;

    typedef struct packed {
        logic [7:0] unimpl;
        logic protect_end_select;
        logic config_page_protect_select;
        logic segment_protect_disable;
        logic [3:0] other_fields;
        logic secondary_osc_select;
        logic battery_brownout_enable;
        logic [6:0] protect_boundary_page;
    } cwd_word3_s;

    typedef struct packed {
        logic [14:0] reserved;
        logic deep_sleep_sw_control;
        logic deep_sleep_watchdog_enable;
        logic deep_sleep_brownout_enable;
        logic deep_sleep_watchdog_clock_select;
        logic [4:0] deep_sleep_watchdog_postscale;
    } cwd_word4_s;

    typedef struct packed {
        logic enable;
        logic [6:0] low_page;
        logic [6:0] high_page;
        logic config_page;
    } cwd_protect_s;

    typedef enum logic [2:0] {
        CWD_SYNC = 3'b001,
        CWD_CAPTURE = 3'b010,
        CWD_HOLD = 3'b100
    } cwd_state_e;

endpackage

`default_nettype wire
